// ### rtl/rcso_framer.sv
// requester completion stream framer: staging window, beat builder, apb registers
// Function
// [R1] valid stays high on every beat from packet start until its last beat is taken
// [R2] a stalled beat is held unchanged until ready returns
// [R3] one keep bit per dword, contiguous from descriptor to last payload dword, pads included
// [R4] keep bits clear only on the final beat of a short packet
// [R5] last is high exactly on each packet's final beat without straddle
// [R6] first start flag marks the descriptor beat of every packet
// [R7] byte enables mark payload bytes only, never descriptor or pad bytes
// [R8] byte enables pass through contiguous; short payloads may be sparse
// [R9] zero-length read completion carries one dword with byte enables all zero
// [R10] receiver ignores second start and end fields unless straddling
// [R11] address-aligned payload begins on the beat after the descriptor
// [R12] address-aligned first payload dword sits at the request's dword offset
// [R13] straddle starts a second packet only after one ended at dword 0..3
// [R14] straddle only allowed in dword-aligned mode
// [R15] straddling forces keep all ones and last low
// [R16] straddle first start flag: packet at lane 0, or lane 16 after an end
// [R17] second start flag for two starts, only after an end before byte 16
// [R18] first end field: flag bit 0, last dword offset, 0..3 if two end
// [R19] second end field: flag bit 0, last dword offset 6 or 7
// [R20] second start implies first start; second end implies first end
// [R21] discontinue on the final beat of a data completion with a memory error
// [R22] receiver discards a whole packet flagged with discontinue
// [R23] no second start in a beat carrying discontinue; the code only blocks it when the first packet of the beat is the aborted one
// [R24] dword-aligned packet is three descriptor dwords then payload dwords
// [R25] width, alignment mode and straddle change only while idle
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module rcso_framer
    import rcso_pkg::*;
#(
    parameter int LANES = 8
) (
    input  wire logic                  clock_i,
    input  wire logic                  rstn_i,
    // apb slave
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [7:0]            paddr_i,
    input  wire logic [31:0]           pwdata_i,
    output logic      [31:0]           prdata_o,
    output logic                       pready_o,
    output logic                       pslverr_o,
    // completion source: descriptor beat, then payload beats packed from lane 0
    input  wire logic                  src_valid_i,
    output logic                       src_ready_o,
    input  wire logic [LANES*32-1:0]   src_data_i,
    input  wire logic [LANES*4-1:0]    src_be_i,
    input  wire logic [3:0]            src_cnt_i,
    input  wire logic                  src_sop_i,
    input  wire logic                  src_eop_i,
    input  wire logic                  src_err_i,
    input  wire logic [2:0]            src_off_i,
    // completion stream to user logic
    output logic                       cpl_out_valid_o,
    input  wire logic                  cpl_out_ready_i,
    output logic      [LANES*32-1:0]   cpl_out_data_o,
    output logic      [LANES-1:0]      cpl_out_dword_keep_o,
    output logic                       cpl_out_last_o,
    output rcso_sband_t                cpl_out_sideband_o,
    output logic                       fatal_o
);

    // lane-count constants
    localparam logic [5:0]  L6       = 6'(LANES);
    localparam logic [5:0]  LMASK    = 6'(LANES - 1);
    localparam logic [7:0]  KEEP_ALL = 8'((1 << LANES) - 1);
    localparam logic [5:0]  TWO_L    = 6'(2 * LANES);

    logic [1:0]  rst_sync_q;
    logic        rstn_s;
    rcso_state_t s_q;
    rcso_state_t s_d;

    // reset release through two flops; only the second is read
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rstn_s = rst_sync_q[1];

    // next-state helpers
    logic        apb_acc;
    logic        out_free;
    logic        emit;
    logic        take;
    logic        strad;
    logic        aa;
    logic        disc_in;
    logic        idle;
    logic        padk;
    logic [5:0]  fp;
    logic [5:0]  wr_end;
    logic [5:0]  nf;
    logic [5:0]  off_l;
    rcso_ent_t   e;

    assign aa    = s_q.cfg[RCSO_CTRL_AA];
    assign strad = s_q.cfg[RCSO_CTRL_STRAD];

    // next state of the whole framer
    always_comb begin
        s_d      = s_q;
        apb_acc  = psel_i & penable_i;
        out_free = !s_q.o_valid | cpl_out_ready_i;
        emit     = out_free & (s_q.fill >= L6);
        take     = src_valid_i & s_q.src_rdy;
        fp       = emit ? s_q.fill - L6 : s_q.fill;
        wr_end   = take ? fp + 6'(src_cnt_i) : fp;
        off_l    = 6'(src_off_i) & LMASK;
        disc_in  = take & src_eop_i & !src_sop_i & src_err_i; // [R21]
        idle     = (s_q.fill == 6'h00) & !s_q.o_valid & !s_q.in_pkt;
        nf       = wr_end;
        padk     = 1'b1;
        e        = '0;

        // apb: answer one cycle after the access phase opens
        s_d.pready  = 1'b0;
        s_d.pslverr = 1'b0;
        if (apb_acc & !s_q.pready) begin
            s_d.pready = 1'b1;
            unique case (paddr_i)
                RCSO_CTRL_OFS: s_d.prdata = {30'h0, s_q.ctrl};
                RCSO_STAT_OFS: s_d.prdata = {28'h0, !idle, s_q.fatal, s_q.cfg};
                RCSO_PCNT_OFS: s_d.prdata = {16'h0, s_q.pkt_cnt};
                default: begin
                    s_d.prdata  = 32'h0;
                    s_d.pslverr = 1'b1;
                end
            endcase
        end

        // writes land on the edge that completes the transfer
        if (apb_acc & s_q.pready & pwrite_i) begin
            if (paddr_i == RCSO_CTRL_OFS) begin
                s_d.ctrl = pwdata_i[1:0];
            end
            if (paddr_i == RCSO_STAT_OFS && pwdata_i[RCSO_STAT_FATAL]) begin
                s_d.fatal = 1'b0;
            end
        end
        // a memory error latches fatal
        if (disc_in) begin
            s_d.fatal = 1'b1; // set after clear, so a new error is never lost
        end

        // configuration only follows the register while nothing is in flight
        if (idle && !take && s_q.phase == RCSO_PH_FLOW) begin
            s_d.cfg[RCSO_CTRL_AA]    = s_q.ctrl[RCSO_CTRL_AA];                      // [R25]
            s_d.cfg[RCSO_CTRL_STRAD] = s_q.ctrl[RCSO_CTRL_STRAD]                    // [R14]
                                       & !s_q.ctrl[RCSO_CTRL_AA] & (LANES == 8);
        end

        // where the write pointer ends up after this source beat
        if (take) begin
            if (src_eop_i) begin
                padk = 1'b0; // trailing pads of a final beat are not kept [R4]
                if (strad && !disc_in && wr_end <= RCSO_SLOT_LANE) begin
                    nf        = RCSO_SLOT_LANE;     // [R13] [R23]
                    s_d.phase = RCSO_PH_SLOT;
                end else begin
                    nf        = (wr_end + LMASK) & ~LMASK;
                    s_d.phase = RCSO_PH_FLOW;
                end
            end else begin
                s_d.phase = RCSO_PH_FLOW;
                if (src_sop_i && aa) begin
                    nf = ((wr_end + LMASK) & ~LMASK) + off_l; // [R11] [R12]
                end
            end
        end else if (s_q.phase == RCSO_PH_SLOT) begin
            // no packet ready to share the beat: close it
            padk      = 1'b0;
            nf        = L6;
            s_d.phase = RCSO_PH_FLOW;
        end

        // staging window: drop the emitted beat, append source dwords, then pads
        for (int i = 0; i < RCSO_SLOTS; i++) begin
            if (!emit) begin
                s_d.slots[i] = s_q.slots[i];
            end else if (i + LANES < RCSO_SLOTS) begin
                s_d.slots[i] = s_q.slots[i + LANES];
            end else begin
                s_d.slots[i] = '0;
            end
            if (take && 6'(i) >= fp && 6'(i) < wr_end) begin
                s_d.slots[i].data  = src_data_i[(i - int'(fp))*32 +: 32];      // [R24]
                s_d.slots[i].be    = src_sop_i ? 4'h0                          // [R7] [R8] [R9]
                                               : src_be_i[(i - int'(fp))*4 +: 4];
                s_d.slots[i].keep  = 1'b1;                                     // [R3]
                s_d.slots[i].start = src_sop_i & (6'(i) == fp);
                s_d.slots[i].endm  = src_eop_i & (6'(i) == wr_end - 6'h01);
                s_d.slots[i].disc  = disc_in & (6'(i) == wr_end - 6'h01);
            end else if (6'(i) >= wr_end && 6'(i) < nf) begin
                s_d.slots[i]      = '0;
                s_d.slots[i].keep = padk; // null pads inside a packet stay kept [R3]
            end
        end
        s_d.fill    = nf;
        s_d.src_rdy = (nf <= TWO_L);

        // packet open flag and completion count
        if (take & src_sop_i & !src_eop_i) begin
            s_d.in_pkt = 1'b1;
        end else if (take & src_eop_i) begin
            s_d.in_pkt = 1'b0;
        end
        if (take & src_eop_i) begin
            s_d.pkt_cnt = s_q.pkt_cnt + 16'h0001;
        end

        // output stage: the beat stands until it is taken [R2]
        if (s_q.o_valid & cpl_out_ready_i) begin
            s_d.o_valid = 1'b0;
        end
        if (emit) begin
            s_d.o_valid = 1'b1; // full rate source keeps beats back to back [R1]
            s_d.o_data  = '0;
            s_d.o_keep  = '0;
            s_d.o_last  = 1'b0;
            s_d.o_sb    = '0;
            for (int i = 0; i < LANES; i++) begin
                e = s_q.slots[i];
                s_d.o_data[i*32 +: 32]     = e.data;
                s_d.o_keep[i]              = e.keep;
                s_d.o_sb.byte_en[i*4 +: 4] = e.be;                            // [R7]
                s_d.o_sb.discontinue       = s_d.o_sb.discontinue | e.disc;   // [R21]
                if (e.start) begin
                    if (s_d.o_sb.first_start_flag) begin
                        s_d.o_sb.second_start_flag = strad;                   // [R17] [R20]
                    end else begin
                        s_d.o_sb.first_start_flag = 1'b1;                     // [R6] [R16]
                    end
                end
                if (e.endm) begin
                    s_d.o_last = 1'b1;                                        // [R5]
                    if (s_d.o_sb.first_end_field[0]) begin
                        s_d.o_sb.second_end_field = {3'(i), strad};           // [R19] [R20]
                    end else begin
                        s_d.o_sb.first_end_field = {3'(i), strad};            // [R18]
                    end
                end
            end
            if (strad) begin
                s_d.o_keep = KEEP_ALL;                                        // [R15]
                s_d.o_last = 1'b0;
            end else begin
                s_d.o_sb.first_end_field  = 4'h0; // unused fields held at zero [R10]
                s_d.o_sb.second_end_field = 4'h0;
            end
        end
    end

    // single state register
    always_ff @(posedge clock_i or negedge rstn_s) begin
        if (!rstn_s) begin
            s_q         <= '0;
            s_q.phase   <= RCSO_PH_FLOW;
            s_q.src_rdy <= 1'b1;
            s_q.ctrl    <= RCSO_CTRL_RST;
            s_q.cfg     <= RCSO_CTRL_RST;
            s_q.pkt_cnt <= RCSO_PCNT_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign prdata_o             = s_q.prdata;
    assign pready_o             = s_q.pready;
    assign pslverr_o            = s_q.pslverr;
    assign src_ready_o          = s_q.src_rdy;
    assign cpl_out_valid_o      = s_q.o_valid;
    assign cpl_out_data_o       = s_q.o_data[LANES*32-1:0];
    assign cpl_out_dword_keep_o = s_q.o_keep[LANES-1:0];
    assign cpl_out_last_o       = s_q.o_last;
    assign cpl_out_sideband_o   = s_q.o_sb;
    assign fatal_o              = s_q.fatal;

    // helper: inside a non-straddled packet between its first and last beat
    logic opkt_q;
    always_ff @(posedge clock_i or negedge rstn_s) begin
        if (!rstn_s) begin
            opkt_q <= 1'b0;
        end else if (s_q.o_valid & cpl_out_ready_i & !strad) begin
            opkt_q <= !s_q.o_last;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_s);

    sequence stalled_beat;
        s_q.o_valid && !cpl_out_ready_i;
    endsequence

    sequence apb_open;
        psel_i && penable_i && !s_q.pready;
    endsequence

    sequence disc_shown;
        s_q.o_valid && s_q.o_sb.discontinue;
    endsequence

    // stream framing
    beat_hold_a: assert property (stalled_beat |=> s_q.o_valid && $stable(s_q.o_data) // [R2]
        && $stable(s_q.o_keep) && $stable(s_q.o_last) && $stable(s_q.o_sb))
        else $error("stalled beat changed");

    pkt_gap_a: assert property (opkt_q && !strad |-> s_q.o_valid) // [R1]
        else $error("valid dropped inside a packet");

    keep_contig_a: assert property (s_q.o_valid |-> ((s_q.o_keep + 8'h01) & s_q.o_keep) == 8'h00) // [R3]
        else $error("keep not contiguous");

    keep_full_a: assert property (s_q.o_valid && !strad && !s_q.o_last // [R4]
        |-> s_q.o_keep == KEEP_ALL)
        else $error("keep cleared on a middle beat");

    first_beat_a: assert property (s_q.o_valid && !strad && !opkt_q // [R6]
        |-> s_q.o_sb.first_start_flag)
        else $error("first beat without start flag");

    desc_be_a: assert property (s_q.o_valid && s_q.o_sb.first_start_flag && !strad // [R7]
        |-> s_q.o_sb.byte_en[11:0] == 12'h000)
        else $error("descriptor bytes enabled");

    // straddle flags
    strad_frame_a: assert property (strad && s_q.o_valid // [R15]
        |-> s_q.o_keep == KEEP_ALL && !s_q.o_last)
        else $error("straddle beat with keep or last");

    strad_mode_a: assert property (strad |-> !aa && LANES == 8) // [R14]
        else $error("straddle outside dword-aligned 256-bit");

    start_pair_a: assert property (s_q.o_sb.second_start_flag // [R20] [R17] [R23]
        |-> s_q.o_sb.first_start_flag && s_q.o_sb.first_end_field[0]
            && s_q.o_sb.first_end_field[3:1] <= RCSO_SLOT_LAST && !s_q.o_sb.discontinue)
        else $error("second start without an early end");

    end_pair_a: assert property (s_q.o_sb.second_end_field[0] // [R18] [R19] [R20]
        |-> s_q.o_sb.first_end_field[0] && s_q.o_sb.first_end_field[3:1] <= RCSO_SLOT_LAST
            && s_q.o_sb.second_end_field[3:2] == 2'h3)
        else $error("bad second end field");

    // config and abort
    cfg_idle_a: assert property (!$stable(s_q.cfg) |-> $past(idle) && !$past(take)) // [R25]
        else $error("configuration changed while busy");

    disc_fatal_a: assert property (disc_in |=> s_q.fatal ##[0:40] disc_shown) // [R21]
        else $error("memory error not flagged fatal");

    disc_last_a: assert property (s_q.o_valid && s_q.o_sb.discontinue && !strad // [R21]
        |-> s_q.o_last)
        else $error("discontinue off the final beat");

    // register bus
    apb_answer_a: assert property (apb_open |=> s_q.pready ##1 !s_q.pready)
        else $error("apb answer not one cycle");

endmodule // rcso_framer

`default_nettype wire

// ### rtl/rcso_pkg.sv
// constants, carriers and state layout of the completion stream framer
package rcso_pkg;

    // lane geometry of the widest bus and of the internal staging window
    localparam int          RCSO_MAX_LANES    = 8;
    localparam int          RCSO_SLOTS        = 32;
    localparam int          RCSO_DESC_DWORDS  = 3;
    localparam logic [5:0]  RCSO_SLOT_LANE    = 6'h04;
    localparam logic [2:0]  RCSO_SLOT_LAST    = 3'h3;

    // apb register map, byte addresses
    localparam logic [7:0]  RCSO_CTRL_OFS     = 8'h00;
    localparam logic [7:0]  RCSO_STAT_OFS     = 8'h04;
    localparam logic [7:0]  RCSO_PCNT_OFS     = 8'h08;

    // field positions
    localparam int          RCSO_CTRL_AA      = 0;
    localparam int          RCSO_CTRL_STRAD   = 1;
    localparam int          RCSO_STAT_FATAL   = 2;
    localparam int          RCSO_STAT_BUSY    = 3;

    // values after reset
    localparam logic [1:0]  RCSO_CTRL_RST     = 2'h0;
    localparam logic [15:0] RCSO_PCNT_RST     = 16'h0000;

    // phase of the staging window: normal flow, or lane 4 held open
    typedef enum logic [0:0] {
        RCSO_PH_FLOW = 1'b0,
        RCSO_PH_SLOT = 1'b1
    } rcso_phase_t;

    // one dword lane in the staging window
    typedef struct packed {
        logic [31:0] data;
        logic [3:0]  be;
        logic        keep;
        logic        start;
        logic        endm;
        logic        disc;
    } rcso_ent_t;

    // sideband carried beside every output beat
    typedef struct packed {
        logic [31:0] byte_en;
        logic        first_start_flag;
        logic        second_start_flag;
        logic [3:0]  first_end_field;
        logic [3:0]  second_end_field;
        logic        discontinue;
    } rcso_sband_t;

    // whole state of the framer
    typedef struct packed {
        rcso_ent_t [RCSO_SLOTS-1:0]     slots;
        logic [5:0]                     fill;
        rcso_phase_t                    phase;
        logic                           in_pkt;
        logic                           src_rdy;
        logic [1:0]                     ctrl;
        logic [1:0]                     cfg;
        logic                           fatal;
        logic [15:0]                    pkt_cnt;
        logic [RCSO_MAX_LANES*32-1:0]   o_data;
        logic [RCSO_MAX_LANES-1:0]      o_keep;
        logic                           o_last;
        logic                           o_valid;
        rcso_sband_t                    o_sb;
        logic [31:0]                    prdata;
        logic                           pready;
        logic                           pslverr;
    } rcso_state_t;

endpackage

// ### test/rcso_framer_test.sv
// self-checking testbench of the completion stream framer
`timescale 1ns/1ns
`default_nettype none

module rcso_framer_test;
    import rcso_pkg::*;

    typedef struct packed {
        logic [7:0]   keep;
        logic         last;
        rcso_sband_t  sb;
        logic [255:0] data;
    } rcso_tb_beat_t;

    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata_o;
    logic pready_o, pslverr_o, fatal_o;
    logic src_valid = 1'b0, src_sop = 1'b0, src_eop = 1'b0, src_err = 1'b0, src_ready_o;
    logic [255:0] src_data = '0, cpl_out_data_o;
    logic [31:0] src_be = 32'h0;
    logic [3:0] src_cnt = 4'h0;
    logic [2:0] src_off = 3'h0;
    logic cpl_out_valid_o, ready, cpl_out_last_o, stall = 1'b0, strad = 1'b0;
    logic [7:0] cpl_out_dword_keep_o, n_ok, n_drop;
    rcso_sband_t cpl_out_sideband_o;
    int failures = 0, tests_run = 0, dw = 0;
    rcso_tb_beat_t beats[$], cur, prev, last_b;
    logic held = 1'b0, inpkt = 1'b0;
    logic [31:0] rd_d;
    logic rd_e;

    always #5 clock_i = ~clock_i;

    rcso_framer #(.LANES(8)) u_rcso_framer (
        .clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .src_valid_i(src_valid),
        .src_ready_o(src_ready_o), .src_data_i(src_data), .src_be_i(src_be),
        .src_cnt_i(src_cnt), .src_sop_i(src_sop), .src_eop_i(src_eop), .src_err_i(src_err),
        .src_off_i(src_off), .cpl_out_valid_o(cpl_out_valid_o), .cpl_out_ready_i(ready),
        .cpl_out_data_o(cpl_out_data_o), .cpl_out_dword_keep_o(cpl_out_dword_keep_o),
        .cpl_out_last_o(cpl_out_last_o), .cpl_out_sideband_o(cpl_out_sideband_o),
        .fatal_o(fatal_o));

    rcso_sink u_rcso_sink (
        .clock_i(clock_i), .rstn_i(rstn_i), .stall_i(stall), .straddle_i(strad),
        .valid_i(cpl_out_valid_o), .last_i(cpl_out_last_o), .sb_i(cpl_out_sideband_o),
        .ready_o(ready), .ok_o(n_ok), .drop_o(n_drop));

    task automatic chk(input string nm, input logic [311:0] e, input logic [311:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // monitor: taken beats, held beats, gapless packets
    always @(posedge clock_i) begin
        cur = {cpl_out_dword_keep_o, cpl_out_last_o, cpl_out_sideband_o, cpl_out_data_o};
        if (rstn_i !== 1'b1) begin
            held = 1'b0;
            inpkt = 1'b0;
        end else begin
            if (held) chk("held beat", prev, cur);
            if (inpkt && !strad) chk("valid in packet", 1'b1, cpl_out_valid_o);
            held = cpl_out_valid_o && !ready;
            prev = cur;
            if (cpl_out_valid_o && ready) begin
                beats.push_back(cur);
                inpkt = !cpl_out_last_o;
            end
        end
    end

    // apb master: setup, then access held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock_i);
        penable <= 1'b1;
        do @(posedge clock_i); while (pready_o !== 1'b1);
        rd_d = prdata_o;
        rd_e = pslverr_o;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h0);
        chk("read data", e, rd_d);
        chk("read error", ee, rd_e);
    endtask

    // one source beat; dwords numbered for tracing
    task automatic src(input logic s, e, r, input logic [3:0] c, input logic [2:0] o,
                       input logic [31:0] be);
        logic [255:0] d;
        d = '0;
        for (int i = 0; i < c; i++) d[i*32+:32] = 32'hC0DE_0000 + 32'(dw + i);
        dw += c;
        src_valid <= 1'b1;
        src_sop <= s;
        src_eop <= e;
        src_err <= r;
        src_cnt <= c;
        src_off <= o;
        src_be <= be;
        src_data <= d;
        do @(posedge clock_i); while (src_ready_o !== 1'b1);
    endtask

    // descriptor beat, then n payload dwords in one beat when n is not zero
    task automatic cpl(input logic [3:0] n, input logic [31:0] be, input logic r,
                       input logic [2:0] o);
        src(1'b1, n == 4'h0, 1'b0, 4'h3, o, 32'h0);
        if (n != 4'h0) src(1'b0, 1'b1, r, n, 3'h0, be);
    endtask

    // flags packed as start0, start1, end0, end1, discontinue
    task automatic exp_beat(input logic [7:0] k, input logic l, input logic [10:0] f,
                            input logic [31:0] be);
        int n;
        n = 0;
        while (beats.size() == 0 && n < 400) begin
            @(posedge clock_i);
            n++;
        end
        if (beats.size() == 0) chk("beat present", 1'b1, 1'b0);
        else begin
            last_b = beats.pop_front();
            chk("keep", k, last_b.keep);
            chk("last", l, last_b.last);
            chk("flags", f, {last_b.sb.first_start_flag, last_b.sb.second_start_flag,
                last_b.sb.first_end_field, last_b.sb.second_end_field, last_b.sb.discontinue});
            chk("byte enables", be, last_b.sb.byte_en);
        end
    endtask

    initial begin
        repeat (5000) @(posedge clock_i);
        failures++;
        results();
    end

    initial begin
        repeat (6) @(posedge clock_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        chk("idle source ready", 1'b1, src_ready_o);
        chk("idle valid", 1'b0, cpl_out_valid_o);
        rdchk(RCSO_CTRL_OFS, 32'h0, 1'b0);
        rdchk(RCSO_STAT_OFS, 32'h0, 1'b0);
        rdchk(RCSO_PCNT_OFS, 32'h0, 1'b0);
        rdchk(8'h0C, 32'h0, 1'b1);
        // sparse short payload then a two-beat packet, back to back, receiver stalling
        stall <= 1'b1;
        cpl(4'h2, 32'h0000_0081, 1'b0, 3'h0);
        cpl(4'h8, 32'hFFFF_FFFF, 1'b0, 3'h0);
        src_valid <= 1'b0;
        exp_beat(8'h1F, 1'b1, 11'h400, 32'h0008_1000);
        chk("payload lanes", {32'hC0DE_0004, 32'hC0DE_0003}, last_b.data[159:96]);
        exp_beat(8'hFF, 1'b0, 11'h400, 32'hFFFF_F000);
        exp_beat(8'h07, 1'b1, 11'h000, 32'h0000_0FFF);
        stall <= 1'b0;
        // zero-length read, no-data completion, aborted completion
        cpl(4'h1, 32'h0, 1'b0, 3'h0);
        cpl(4'h0, 32'h0, 1'b0, 3'h0);
        cpl(4'h1, 32'h0000_000F, 1'b1, 3'h0);
        src_valid <= 1'b0;
        exp_beat(8'h0F, 1'b1, 11'h400, 32'h0);
        exp_beat(8'h07, 1'b1, 11'h400, 32'h0);
        exp_beat(8'h0F, 1'b1, 11'h401, 32'h0000_F000);
        chk("fatal flag", 1'b1, fatal_o);
        rdchk(RCSO_STAT_OFS, 32'h4, 1'b0);
        apb(1'b1, RCSO_STAT_OFS, 32'h4);
        rdchk(RCSO_STAT_OFS, 32'h0, 1'b0);
        rdchk(RCSO_PCNT_OFS, 32'h5, 1'b0);
        // address aligned, payload at dword offset 2
        apb(1'b1, RCSO_CTRL_OFS, 32'h1);
        rdchk(RCSO_STAT_OFS, 32'h1, 1'b0);
        cpl(4'h1, 32'h0000_000F, 1'b0, 3'h2);
        src_valid <= 1'b0;
        exp_beat(8'hFF, 1'b0, 11'h400, 32'h0);
        exp_beat(8'h07, 1'b1, 11'h000, 32'h0000_0F00);
        // straddle requested with address aligned stays unstraddled
        apb(1'b1, RCSO_CTRL_OFS, 32'h3);
        rdchk(RCSO_STAT_OFS, 32'h1, 1'b0);
        cpl(4'h0, 32'h0, 1'b0, 3'h0);
        src_valid <= 1'b0;
        exp_beat(8'h07, 1'b1, 11'h400, 32'h0);
        // straddle: two packets in one beat, then abort blocks the second start
        apb(1'b1, RCSO_CTRL_OFS, 32'h2);
        rdchk(RCSO_STAT_OFS, 32'h2, 1'b0);
        strad <= 1'b1;
        cpl(4'h1, 32'h0000_000F, 1'b0, 3'h0);
        cpl(4'h0, 32'h0, 1'b0, 3'h0);
        src_valid <= 1'b0;
        exp_beat(8'hFF, 1'b0, {2'b11, 4'h7, 4'hD, 1'b0}, 32'h0000_F000);
        cpl(4'h1, 32'h0000_000F, 1'b1, 3'h0);
        cpl(4'h0, 32'h0, 1'b0, 3'h0);
        src_valid <= 1'b0;
        exp_beat(8'hFF, 1'b0, {2'b10, 4'h7, 4'h0, 1'b1}, 32'h0000_F000);
        exp_beat(8'hFF, 1'b0, {2'b10, 4'h5, 4'h0, 1'b0}, 32'h0);
        repeat (2) @(posedge clock_i);
        chk("packets received", 8'd9, n_ok);
        chk("packets dropped", 8'd2, n_drop);
        results();
    end
endmodule // rcso_framer_test

`default_nettype wire

// ### test/rcso_sink.sv
// far-side model: user logic that takes completion beats, stalls, drops aborted packets
`timescale 1ns/1ns
`default_nettype none

module rcso_sink
    import rcso_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        rstn_i,
    input  wire logic        stall_i,
    input  wire logic        straddle_i,
    input  wire logic        valid_i,
    input  wire logic        last_i,
    input  wire rcso_sband_t sb_i,
    output logic             ready_o,
    output logic [7:0]       ok_o,
    output logic [7:0]       drop_o
);
    logic [1:0] ph_q;
    logic [1:0] ends;
    logic       take;

    // end markers: last alone unless straddling, where the end fields take over
    always_comb begin
        take = valid_i && ready_o;
        ends = straddle_i ? {sb_i.second_end_field[0], sb_i.first_end_field[0]} : {1'b0, last_i};
    end

    // an aborted packet in the first end field is counted as dropped; a second end in that beat still counts as received
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ph_q    <= 2'h0;
            ready_o <= 1'b0;
            ok_o    <= 8'h00;
            drop_o  <= 8'h00;
        end else begin
            ph_q    <= ph_q + 2'h1;
            // stalls three cycles in four so held beats get exercised
            ready_o <= !stall_i || (ph_q == 2'h3);
            if (take) begin
                ok_o   <= ok_o + {7'h0, ends[0] && !sb_i.discontinue} + {7'h0, ends[1]};
                drop_o <= drop_o + {7'h0, ends[0] && sb_i.discontinue};
            end
        end
    end
endmodule // rcso_sink

`default_nettype wire
